// ### design/cl_cfg_pkg.sv
package cl_cfg_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12; // Byte address width on the bus
  localparam int DATA_W = 32; // Register word width
  localparam int STRB_W = DATA_W / 8; // Byte lanes
  localparam int IDX_SHIFT = 2; // Word index to byte address

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_STOP_MOTOR = 8'h8A;
  localparam logic [7:0] IDX_CURR_GAINS = 8'h8C;
  localparam logic [7:0] IDX_SPEED_GAINS = 8'h8E;

  // Reset values of the three words
  localparam logic [31:0] RST_STOP_MOTOR = 32'h00000000;
  localparam logic [31:0] RST_CURR_GAINS = 32'h00000000;
  localparam logic [13:0] RST_MAX_SPEED_DEF = 14'h0000;

  // AXI4-Lite responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int PARITY_BIT = 31;
  localparam int STOP_LSB = 28; // 3 bits
  localparam int BRK_TIME_LSB = 24; // 4 bits
  localparam int SPIN_THR_LSB = 20; // 4 bits
  localparam int BRK_THR_LSB = 16; // 4 bits
  localparam int RES_LSB = 8; // 8 bits
  localparam int IND_LSB = 0; // 8 bits
  localparam int BEMF_LSB = 23; // 8 bits
  localparam int CKP_LSB = 13; // 10 bits
  localparam int CKI_LSB = 3; // 10 bits
  localparam int SKP_HI_LSB = 0; // 3 bits, top of speed kp
  localparam int SKP_LO_LSB = 24; // 7 bits, bottom of speed kp
  localparam int SKI_LSB = 14; // 10 bits
  localparam int MAXSPD_LSB = 0; // 14 bits
  localparam logic [13:0] MAX_SPEED_DIV = 14'h0006; // Code per Hz

  // ---------------------------------------------------------------
  // Stop behaviour and lookup tables
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    STOP_HIZ, STOP_RECIRC, STOP_LS_BRAKE, STOP_HS_BRAKE,
    STOP_SPIN_DOWN, STOP_ALIGN_BRAKE, STOP_UNUSED
  } stop_method_t;

  // Brake time in units of 10 us, indexed by code
  localparam logic [20:0] BRK_TIME_10US [16] = '{
    21'h00000A, 21'h00000A, 21'h000019, 21'h000032,
    21'h000064, 21'h0001F4, 21'h0003E8, 21'h001388,
    21'h002710, 21'h0061A8, 21'h00C350, 21'h0186A0,
    21'h03D090, 21'h07A120, 21'h0F4240, 21'h16E360};

  // Speed threshold in tenths of a percent, indexed by code
  localparam logic [10:0] THR_PERMILLE [16] = '{
    11'h3E8, 11'h384, 11'h320, 11'h2BC, 11'h258, 11'h1F4,
    11'h1C2, 11'h190, 11'h15E, 11'h12C, 11'h0FA, 11'h0C8,
    11'h096, 11'h064, 11'h032, 11'h019};

endpackage

// ### design/gain_code_split.sv
`timescale 1ns/1ps
module gain_code_split (
  // Packed gain code
  input wire logic [9:0] i_code,
  // Decoded parts
  output logic [7:0] o_mant,
  output logic [1:0] o_exp,
  output logic o_auto
);

  // ---------------------------------------------------------------
  // Mantissa over ten to the exponent
  // ---------------------------------------------------------------
  // Scale factor is fixed per gain and applied downstream
  always_comb begin
    o_mant = i_code[7:0];
    o_exp = i_code[9:8];
    // Zero code hands the gain to the automatic tuner
    o_auto = (i_code == 10'h000);
  end

endmodule

// ### design/closed_loop_stop_config_regs.sv
`timescale 1ns/1ps
// Function
// - Stop word at index 8A, zero reset, parity
// - Bits 30-28 pick the stop behaviour
// - Bits 27-24 map to brake time
// - Bits 23-20 spin-down threshold percent table
// - Bits 19-16 brake threshold, same table
// - Phase resistance 15-8, inductance 7-0
// - Current gains word at 8C, zero reset
// - Back-EMF constant in bits 30-23
// - Current kp bits 22-13, mantissa/exponent
// - Zero current kp means automatic gain
// - Zero current ki means automatic gain
// - Bits 2-0 are speed kp top bits
// - Speed word at 8E, parity bit 31
// - Bits 30-24 speed kp low, zero auto
// - Speed ki bits 23-14, zero auto
// - Max speed bits 13-0, Hz is code/6
module closed_loop_stop_config_regs #(
  parameter logic [13:0] MAX_SPEED_RESET = cl_cfg_pkg::RST_MAX_SPEED_DEF
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RSTN,
  // AXI4-Lite write address and data
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [cl_cfg_pkg::ADDR_W-1:0] I_AWADDR,
  input wire logic [2:0] I_AWPROT,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [cl_cfg_pkg::DATA_W-1:0] I_WDATA,
  input wire logic [cl_cfg_pkg::STRB_W-1:0] I_WSTRB,
  // AXI4-Lite write response
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  // AXI4-Lite read
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [cl_cfg_pkg::ADDR_W-1:0] I_ARADDR,
  input wire logic [2:0] I_ARPROT,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [cl_cfg_pkg::DATA_W-1:0] O_RDATA,
  output logic [1:0] O_RRESP,
  // Stop configuration
  output cl_cfg_pkg::stop_method_t O_STOP_METHOD,
  output logic [20:0] O_BRAKE_TIME_10US,
  output logic [10:0] O_SPIN_THR_PERMILLE,
  output logic [10:0] O_BRAKE_THR_PERMILLE,
  // Motor model
  output logic [7:0] O_PHASE_RES,
  output logic [7:0] O_PHASE_IND,
  output logic [7:0] O_BEMF_CONST,
  // Loop gains: mantissa, exponent, automatic flag
  output logic [7:0] O_CKP_MANT,
  output logic [1:0] O_CKP_EXP,
  output logic O_CKP_AUTO,
  output logic [7:0] O_CKI_MANT,
  output logic [1:0] O_CKI_EXP,
  output logic O_CKI_AUTO,
  output logic [7:0] O_SKP_MANT,
  output logic [1:0] O_SKP_EXP,
  output logic O_SKP_AUTO,
  output logic [7:0] O_SKI_MANT,
  output logic [1:0] O_SKI_EXP,
  output logic O_SKI_AUTO,
  // Speed limit
  output logic [13:0] O_MAX_SPEED_CODE,
  output logic [13:0] O_MAX_SPEED_HZ
);
  import cl_cfg_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Map a byte address to a register slot, 0 when unmapped
  function automatic logic [1:0] reg_slot(input logic [ADDR_W-1:0] a);
    logic [1:0] s;
    s = 2'h0;
    if (a == ADDR_W'({IDX_STOP_MOTOR, 2'h0})) begin
      s = 2'h1;
    end else if (a == ADDR_W'({IDX_CURR_GAINS, 2'h0})) begin
      s = 2'h2;
    end else if (a == ADDR_W'({IDX_SPEED_GAINS, 2'h0})) begin
      s = 2'h3;
    end
    return s;
  endfunction

  // Merge write data into a word lane by lane
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < STRB_W; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_meta_q; // First stage, read only by the second
  logic rst_n_q; // Released reset used everywhere else

  // Assert at once, release after two edges
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // Register words and write channel
  // ---------------------------------------------------------------
  logic [31:0] stop_and_motor_params_q, stop_and_motor_params_d;
  logic [31:0] current_loop_gains_q, current_loop_gains_d;
  logic [31:0] speed_loop_gains_and_limit_q, speed_loop_gains_and_limit_d;
  logic aw_hold_q, aw_hold_d; // Address taken, waiting for data
  logic w_hold_q, w_hold_d; // Data taken, waiting for address
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic commit; // Both halves present, write lands now
  logic [1:0] wr_slot;

  // Either half may arrive first; commit once both are held
  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    aw_addr_d = aw_addr_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    stop_and_motor_params_d = stop_and_motor_params_q;
    current_loop_gains_d = current_loop_gains_q;
    speed_loop_gains_and_limit_d = speed_loop_gains_and_limit_q;
    commit = aw_hold_q && w_hold_q && !bvalid_q;
    wr_slot = reg_slot(aw_addr_q);
    // Address half
    if (I_AWVALID && awready_q) begin
      aw_hold_d = 1'b1;
      aw_addr_d = I_AWADDR;
    end
    // Data half
    if (I_WVALID && wready_q) begin
      w_hold_d = 1'b1;
      w_data_d = I_WDATA;
      w_strb_d = I_WSTRB;
    end
    // Response drained
    if (bvalid_q && I_BREADY) begin
      bvalid_d = 1'b0;
    end
    // Every bit, parity included, is plain storage
    if (commit) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      if (wr_slot == 2'h1) begin
        stop_and_motor_params_d = merge(stop_and_motor_params_q,
          w_data_q, w_strb_q);
      end else if (wr_slot == 2'h2) begin
        current_loop_gains_d = merge(current_loop_gains_q,
          w_data_q, w_strb_q);
      end else if (wr_slot == 2'h3) begin
        speed_loop_gains_and_limit_d = merge(
          speed_loop_gains_and_limit_q,
          w_data_q, w_strb_q);
      end else begin
        // Unmapped address: nothing stored
        bresp_d = RESP_SLVERR;
      end
    end
    // Hold off new halves while a response is outstanding
    awready_d = !aw_hold_d && !bvalid_d;
    wready_d = !w_hold_d && !bvalid_d;
  end

  // Register the write side
  always_ff @(posedge I_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      stop_and_motor_params_q <= RST_STOP_MOTOR;
      current_loop_gains_q <= RST_CURR_GAINS;
      speed_loop_gains_and_limit_q <= {18'h00000,
        MAX_SPEED_RESET};
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      stop_and_motor_params_q <= stop_and_motor_params_d;
      current_loop_gains_q <= current_loop_gains_d;
      speed_loop_gains_and_limit_q <= speed_loop_gains_and_limit_d;
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      aw_addr_q <= aw_addr_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic [1:0] rd_slot;

  // One read in flight; reads have no side effects
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    rd_slot = reg_slot(I_ARADDR);
    if (rvalid_q && I_RREADY) begin
      rvalid_d = 1'b0;
    end
    if (I_ARVALID && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      if (rd_slot == 2'h1) begin
        rdata_d = stop_and_motor_params_q;
      end else if (rd_slot == 2'h2) begin
        rdata_d = current_loop_gains_q;
      end else if (rd_slot == 2'h3) begin
        rdata_d = speed_loop_gains_and_limit_q;
      end else begin
        // Unmapped reads return zero with an error
        rdata_d = 32'h00000000;
        rresp_d = RESP_SLVERR;
      end
    end
    arready_d = !rvalid_d;
  end

  // Register the read side
  always_ff @(posedge I_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ---------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------
  logic [31:0] w2, w3, w4; // Short aliases of the three words
  assign w2 = stop_and_motor_params_q;
  assign w3 = current_loop_gains_q;
  assign w4 = speed_loop_gains_and_limit_q;

  // Gain codes; speed kp straddles two words
  logic [9:0] skp_code;
  assign skp_code = {w3[SKP_HI_LSB +: 3], w4[SKP_LO_LSB +: 7]};
  logic [7:0] ckp_m, cki_m, skp_m, ski_m;
  logic [1:0] ckp_e, cki_e, skp_e, ski_e;
  logic ckp_a, cki_a, skp_a, ski_a;

  // Current kp, unit scale, both axes share it
  gain_code_split u_ckp (.i_code(w3[CKP_LSB +: 10]), .o_mant(ckp_m),
    .o_exp(ckp_e), .o_auto(ckp_a));
  // Current ki, scale 1000
  gain_code_split u_cki (.i_code(w3[CKI_LSB +: 10]), .o_mant(cki_m),
    .o_exp(cki_e), .o_auto(cki_a));
  // Speed kp, scale 0.01
  gain_code_split u_skp (.i_code(skp_code), .o_mant(skp_m),
    .o_exp(skp_e), .o_auto(skp_a));
  // Speed ki, scale 0.1
  gain_code_split u_ski (.i_code(w4[SKI_LSB +: 10]), .o_mant(ski_m),
    .o_exp(ski_e), .o_auto(ski_a));

  stop_method_t stop_d;

  // Unused stop codes collapse to one marker value
  always_comb begin
    if (w2[STOP_LSB +: 3] > 3'(STOP_ALIGN_BRAKE)) begin
      stop_d = STOP_UNUSED;
    end else begin
      stop_d = stop_method_t'(w2[STOP_LSB +: 3]);
    end
  end

  // Outputs lag the stored words by one edge, glitch free
  always_ff @(posedge I_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      // Reset state is the decode of the reset words, so no false step
      O_STOP_METHOD <= STOP_HIZ;
      O_BRAKE_TIME_10US <= BRK_TIME_10US[RST_STOP_MOTOR[BRK_TIME_LSB +: 4]];
      O_SPIN_THR_PERMILLE <= THR_PERMILLE[RST_STOP_MOTOR[SPIN_THR_LSB +: 4]];
      O_BRAKE_THR_PERMILLE <= THR_PERMILLE[RST_STOP_MOTOR[BRK_THR_LSB +: 4]];
      O_PHASE_RES <= 8'h00;
      O_PHASE_IND <= 8'h00;
      O_BEMF_CONST <= 8'h00;
      // Zero reset codes select the automatic gains
      {O_CKP_MANT, O_CKP_EXP, O_CKP_AUTO} <= 11'h001;
      {O_CKI_MANT, O_CKI_EXP, O_CKI_AUTO} <= 11'h001;
      {O_SKP_MANT, O_SKP_EXP, O_SKP_AUTO} <= 11'h001;
      {O_SKI_MANT, O_SKI_EXP, O_SKI_AUTO} <= 11'h001;
      O_MAX_SPEED_CODE <= MAX_SPEED_RESET;
      O_MAX_SPEED_HZ <= MAX_SPEED_RESET / MAX_SPEED_DIV;
    end else begin
      O_STOP_METHOD <= stop_d;
      O_BRAKE_TIME_10US <= BRK_TIME_10US[w2[BRK_TIME_LSB +: 4]];
      O_SPIN_THR_PERMILLE <= THR_PERMILLE[w2[SPIN_THR_LSB +: 4]];
      O_BRAKE_THR_PERMILLE <= THR_PERMILLE[w2[BRK_THR_LSB +: 4]];
      O_PHASE_RES <= w2[RES_LSB +: 8];
      O_PHASE_IND <= w2[IND_LSB +: 8];
      O_BEMF_CONST <= w3[BEMF_LSB +: 8];
      {O_CKP_MANT, O_CKP_EXP, O_CKP_AUTO} <= {ckp_m, ckp_e, ckp_a};
      {O_CKI_MANT, O_CKI_EXP, O_CKI_AUTO} <= {cki_m, cki_e, cki_a};
      {O_SKP_MANT, O_SKP_EXP, O_SKP_AUTO} <= {skp_m, skp_e, skp_a};
      {O_SKI_MANT, O_SKI_EXP, O_SKI_AUTO} <= {ski_m, ski_e, ski_a};
      O_MAX_SPEED_CODE <= w4[MAXSPD_LSB +: 14];
      // Constant divider; short path, no multicycle needed
      O_MAX_SPEED_HZ <= w4[MAXSPD_LSB +: 14] / MAX_SPEED_DIV;
    end
  end

  // Bus outputs straight from their flops
  assign O_AWREADY = awready_q;
  assign O_WREADY = wready_q;
  assign O_BVALID = bvalid_q;
  assign O_BRESP = bresp_q;
  assign O_ARREADY = arready_q;
  assign O_RVALID = rvalid_q;
  assign O_RDATA = rdata_q;
  assign O_RRESP = rresp_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!rst_n_q);

  sequence full_write_stop;
    commit && wr_slot == 2'h1 && w_strb_q == 4'hF;
  endsequence
  sequence answer_next;
    ##1 bvalid_q && bresp_q == RESP_OKAY;
  endsequence

  stop_store_a: assert property (full_write_stop |-> answer_next
    ##0 stop_and_motor_params_q == $past(w_data_q))
    else $error("stop word not stored");
  resp_hold_a: assert property (bvalid_q |->
    (!awready_q && !wready_q) ##1 (bvalid_q || $past(I_BREADY)))
    else $error("write response dropped");
  rd_back_a: assert property (I_ARVALID && arready_q &&
    reg_slot(I_ARADDR) == 2'h3 |=> rvalid_q &&
    rdata_q == $past(speed_loop_gains_and_limit_q))
    else $error("read data mismatch");
  stop_map_a: assert property (w2[STOP_LSB +: 3] == 3'h5 |=>
    O_STOP_METHOD == STOP_ALIGN_BRAKE)
    else $error("stop method decode wrong");
  brake_time_a: assert property (w2[BRK_TIME_LSB +: 3] == 3'h0
    && w2[BRK_TIME_LSB + 3] == 1'b0 |=> O_BRAKE_TIME_10US == 21'h00000A)
    else $error("shortest brake time wrong");
  spin_top_a: assert property (w2[SPIN_THR_LSB +: 4] == 4'hF |=>
    O_SPIN_THR_PERMILLE == 11'h019)
    else $error("spin threshold decode wrong");
  thr_same_a: assert property (w2[SPIN_THR_LSB +: 4] ==
    w2[BRK_THR_LSB +: 4] |=> O_SPIN_THR_PERMILLE == O_BRAKE_THR_PERMILLE)
    else $error("threshold tables differ");
  ckp_auto_a: assert property (##1 O_CKP_AUTO ==
    ($past(w3[CKP_LSB +: 10]) == 10'h000))
    else $error("current kp auto flag wrong");
  skp_join_a: assert property (##1 {O_SKP_EXP, O_SKP_MANT} ==
    {$past(w3[2:0]), $past(w4[30:24])})
    else $error("speed kp join wrong");
  max_hz_a: assert property (##1 O_MAX_SPEED_HZ ==
    $past(w4[13:0]) / MAX_SPEED_DIV)
    else $error("max speed division wrong");

endmodule

// ### tb/closed_loop_stop_config_regs_tb.sv
`timescale 1ns/1ps
// Compare one value, count it, report a mismatch at once
`define CHK(nm, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); \
  end \
end
module closed_loop_stop_config_regs_tb;
  import cl_cfg_pkg::*;

  // ---------------------------------------------------------------
  // Bench constants
  // ---------------------------------------------------------------
  localparam int LIMIT = 20000; // Ceiling, the run needs about 270
  localparam logic [11:0] A_STOP = {2'h0, IDX_STOP_MOTOR, 2'h0};
  localparam logic [11:0] A_CURR = {2'h0, IDX_CURR_GAINS, 2'h0};
  localparam logic [11:0] A_SPEED = {2'h0, IDX_SPEED_GAINS, 2'h0};
  localparam logic [11:0] A_HOLE = 12'h22C; // Gap between two words
  // Brake time in 10 us units, by code
  localparam logic [20:0] BRK_EXP [16] = '{
    21'h00000A, 21'h00000A, 21'h000019, 21'h000032, 21'h000064,
    21'h0001F4, 21'h0003E8, 21'h001388, 21'h002710, 21'h0061A8,
    21'h00C350, 21'h0186A0, 21'h03D090, 21'h07A120, 21'h0F4240,
    21'h16E360};
  // Speed thresholds in tenths of a percent, by code
  localparam logic [10:0] THR_EXP [16] = '{
    11'h3E8, 11'h384, 11'h320, 11'h2BC, 11'h258, 11'h1F4, 11'h1C2,
    11'h190, 11'h15E, 11'h12C, 11'h0FA, 11'h0C8, 11'h096, 11'h064,
    11'h032, 11'h019};
  // Gain word pairs: current word high half, speed word low half
  localparam logic [63:0] GCASES [4] = '{
    {1'h1, 8'hC3, 10'h2A5, 10'h13C, 3'h5, 1'h1, 7'h5A, 10'h381, 14'h2710},
    {1'h0, 8'h01, 10'h000, 10'h000, 3'h1, 1'h0, 7'h00, 10'h000, 14'h3FFF},
    {1'h0, 8'h00, 10'h000, 10'h000, 3'h0, 1'h0, 7'h01, 10'h000, 14'h0005},
    64'h0000000000000000};

  // ---------------------------------------------------------------
  // Bench signals
  // ---------------------------------------------------------------
  logic clk = 1'b0; // 125 MHz
  logic rstn = 1'b0; // Active low reset
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  stop_method_t stop;
  logic [20:0] brk_time;
  logic [10:0] spin_thr, brk_thr;
  logic [7:0] res, ind, bemf, ckp_m, cki_m, skp_m, ski_m;
  logic [1:0] ckp_e, cki_e, skp_e, ski_e;
  logic ckp_a, cki_a, skp_a, ski_a;
  logic [13:0] max_code, max_hz;
  int n_mismatch = 0; // Mismatches seen
  int comparisons = 0; // Comparisons made
  int cyc = 0; // Cycles since start

  always #4 clk = ~clk;

  closed_loop_stop_config_regs dut (
    .I_CLK(clk), .I_RSTN(rstn),
    .I_AWVALID(awvalid), .O_AWREADY(awready), .I_AWADDR(awaddr),
    .I_AWPROT(3'h0), .I_WVALID(wvalid), .O_WREADY(wready),
    .I_WDATA(wdata), .I_WSTRB(wstrb), .O_BVALID(bvalid),
    .I_BREADY(bready), .O_BRESP(bresp), .I_ARVALID(arvalid),
    .O_ARREADY(arready), .I_ARADDR(araddr), .I_ARPROT(3'h0),
    .O_RVALID(rvalid), .I_RREADY(rready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_STOP_METHOD(stop), .O_BRAKE_TIME_10US(brk_time),
    .O_SPIN_THR_PERMILLE(spin_thr), .O_BRAKE_THR_PERMILLE(brk_thr),
    .O_PHASE_RES(res), .O_PHASE_IND(ind), .O_BEMF_CONST(bemf),
    .O_CKP_MANT(ckp_m), .O_CKP_EXP(ckp_e), .O_CKP_AUTO(ckp_a),
    .O_CKI_MANT(cki_m), .O_CKI_EXP(cki_e), .O_CKI_AUTO(cki_a),
    .O_SKP_MANT(skp_m), .O_SKP_EXP(skp_e), .O_SKP_AUTO(skp_a),
    .O_SKI_MANT(ski_m), .O_SKI_EXP(ski_e), .O_SKI_AUTO(ski_a),
    .O_MAX_SPEED_CODE(max_code), .O_MAX_SPEED_HZ(max_hz)
  );

  // ---------------------------------------------------------------
  // Verdict and hang guard
  // ---------------------------------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // A stuck handshake would otherwise hang the run forever
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      complete_run();
    end
  end

  // ---------------------------------------------------------------
  // Bus tasks, entered just after a rising edge
  // ---------------------------------------------------------------
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [1:0] r);
    logic aw_ok, w_ok, done;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    done = 1'b0;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (aw_ok && w_ok && bvalid === 1'b1) begin
        r = bresp;
        done = 1'b1;
      end
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b0;
    // One edge apart, so the next call never reassigns in this step
    @(posedge clk);
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    logic taken, done;
    taken = 1'b0;
    done = 1'b0;
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (taken && rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        done = 1'b1;
      end
      if (!taken && arready === 1'b1) begin
        taken = 1'b1;
        arvalid <= 1'b0;
      end
    end
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // Read a word and compare data and response
  task automatic read_chk(input logic [11:0] a, input logic [31:0] e,
                          input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    `CHK("read data", e, d)
    `CHK("read resp", er, r)
  endtask

  // Decoded outputs trail the word by one edge
  task automatic settle();
    repeat (2) @(posedge clk);
  endtask

  // Gains, motor constant and speed limit from one pair of words
  task automatic gain_case(input logic [31:0] w3, input logic [31:0] w4);
    logic [9:0] skp;
    logic [1:0] r;
    skp = {w3[2:0], w4[30:24]};
    axi_write(A_CURR, w3, 4'hF, r);
    axi_write(A_SPEED, w4, 4'hF, r);
    `CHK("speed bresp", RESP_OKAY, r)
    settle();
    `CHK("bemf", w3[30:23], bemf)
    `CHK("ckp mant", w3[20:13], ckp_m)
    `CHK("ckp exp", w3[22:21], ckp_e)
    `CHK("ckp auto", w3[22:13] == 10'h000, ckp_a)
    `CHK("cki mant", w3[10:3], cki_m)
    `CHK("cki exp", w3[12:11], cki_e)
    `CHK("cki auto", w3[12:3] == 10'h000, cki_a)
    `CHK("skp mant", skp[7:0], skp_m)
    `CHK("skp exp", skp[9:8], skp_e)
    `CHK("skp auto", skp == 10'h000, skp_a)
    `CHK("ski mant", w4[21:14], ski_m)
    `CHK("ski exp", w4[23:22], ski_e)
    `CHK("ski auto", w4[23:14] == 10'h000, ski_a)
    `CHK("max code", w4[13:0], max_code)
    `CHK("max hz", w4[13:0] / 14'h0006, max_hz)
    read_chk(A_CURR, w3, RESP_OKAY);
    read_chk(A_SPEED, w4, RESP_OKAY);
  endtask

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    logic [3:0] c;
    logic [31:0] w;
    logic [1:0] r;
    repeat (6) @(posedge clk);
    `CHK("awready in reset", 1'b0, awready)
    rstn <= 1'b1;
    @(posedge clk);
    // Reset values and decoded reset state
    read_chk(A_STOP, RST_STOP_MOTOR, RESP_OKAY);
    read_chk(A_CURR, RST_CURR_GAINS, RESP_OKAY);
    read_chk(A_SPEED, 32'h00000000, RESP_OKAY);
    `CHK("stop reset", STOP_HIZ, stop)
    `CHK("brake time reset", 21'h00000A, brk_time)
    `CHK("ckp auto reset", 1'b1, ckp_a)
    $display("test reset done");
    // Every code of each stop field, parity toggled
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      w = {c[0], c[2:0], c, c, 4'hF - c, c, c, ~c, c};
      axi_write(A_STOP, w, 4'hF, r);
      `CHK("stop bresp", RESP_OKAY, r)
      settle();
      `CHK("stop", c[2:0] > 3'h5 ? STOP_UNUSED : c[2:0], stop)
      `CHK("brake time", BRK_EXP[i], brk_time)
      `CHK("spin thr", THR_EXP[i], spin_thr)
      `CHK("brake thr", THR_EXP[15 - i], brk_thr)
      `CHK("res", {c, c}, res)
      `CHK("ind", {~c, c}, ind)
      read_chk(A_STOP, w, RESP_OKAY);
    end
    $display("test stop fields done");
    // One byte lane only
    axi_write(A_STOP, 32'hFFFFFFFF, 4'hF, r);
    axi_write(A_STOP, 32'h00000000, 4'h2, r);
    settle();
    read_chk(A_STOP, 32'hFFFF00FF, RESP_OKAY);
    `CHK("res lane", 8'h00, res)
    `CHK("ind lane", 8'hFF, ind)
    $display("test byte lanes done");
    // Unmapped gap is refused and changes nothing
    axi_write(A_HOLE, 32'h12345678, 4'hF, r);
    `CHK("hole bresp", RESP_SLVERR, r)
    read_chk(A_HOLE, 32'h00000000, RESP_SLVERR);
    read_chk(A_STOP, 32'hFFFF00FF, RESP_OKAY);
    $display("test unmapped done");
    for (int i = 0; i < 4; i++) begin
      gain_case(GCASES[i][63:32], GCASES[i][31:0]);
    end
    $display("test gains done");
    // Second reset in mid-run clears the words
    axi_write(A_CURR, 32'hA5A5A5A5, 4'hF, r);
    read_chk(A_CURR, 32'hA5A5A5A5, RESP_OKAY);
    rstn <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK("arready in reset", 1'b0, arready)
    rstn <= 1'b1;
    @(posedge clk);
    read_chk(A_CURR, 32'h00000000, RESP_OKAY);
    read_chk(A_STOP, 32'h00000000, RESP_OKAY);
    $display("test second reset done");
    complete_run();
  end
endmodule
